// [hw/adcif_regs.sv]
// Top: converter interface register tail with mask, result, channel state and interrupt
`timescale 1ns/1ps
module adcif_regs #(
   parameter int NUM_CH = 10
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic conv_done,
   input wire logic [11:0] conv_value,
   input wire logic [7:0] conv_channel,
   input wire logic [31:0] status_word,
   output logic [NUM_CH-1:0] channel_enable,
   output logic irq
);
   logic [31:0] irq_mask_reg;
   logic [31:0] channel_state_reg;
   logic [11:0] result_value_reg;
   logic [7:0] result_channel_tag_reg;
   logic [31:0] status_prev_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] ch_impl;
   logic [31:0] last_result;
   logic [31:0] module_revision;
   logic wr_unmask;
   logic wr_mask_off;
   logic wr_on;
   logic wr_off;
   logic wr_clear;

   adcif_flag_if fb ();

   adcif_flags #(
      .IMPL(adcif_pkg::IRQ_BITS)
   ) u_flags (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .fb(fb)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Write decode
   assign wr_unmask = wr_en && (addr == adcif_pkg::ADDR_IRQ_UNMASK);
   assign wr_mask_off = wr_en && (addr == adcif_pkg::ADDR_IRQ_MASK_OFF);
   assign wr_on = wr_en && (addr == adcif_pkg::ADDR_CHANNEL_ON);
   assign wr_off = wr_en && (addr == adcif_pkg::ADDR_CHANNEL_OFF);
   assign wr_clear = wr_en && (addr == adcif_pkg::ADDR_IRQ_FLAG_CLEAR);
   // Ten inputs, positions 0 to 9 all present
   assign ch_impl = adcif_pkg::CHANNELS_PRESENT_RST;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt mask
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_reg <= adcif_pkg::IRQ_MASK_RST;
      end else if (wr_unmask) begin
         irq_mask_reg <= irq_mask_reg | (wdata & adcif_pkg::IRQ_BITS);
      end else if (wr_mask_off) begin
         irq_mask_reg <= irq_mask_reg & ~wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel state; software must not disable mid-conversion
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         channel_state_reg <= adcif_pkg::CHANNEL_STATE_RST;
      end else if (wr_on) begin
         channel_state_reg <= channel_state_reg | (wdata & ch_impl);
      end else if (wr_off) begin
         channel_state_reg <= channel_state_reg & ~wdata;
      end
   end
   assign channel_enable = channel_state_reg[NUM_CH-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Last result capture
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         result_value_reg <= adcif_pkg::LAST_RESULT_RST[11:0];
         result_channel_tag_reg <= adcif_pkg::LAST_RESULT_RST[23:16];
      end else if (conv_done) begin
         result_value_reg <= conv_value;
         result_channel_tag_reg <= conv_channel;
      end
   end
   assign last_result = {8'h00, result_channel_tag_reg, 4'h0, result_value_reg};
   assign module_revision = {12'h000, adcif_pkg::REVISION_VARIANT, 4'h0, adcif_pkg::REVISION_NUMBER};

   ////////////////////////////////////////////////////////////////////////////////
   // Flag sources: status rises, and conversion completion
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status_prev_reg <= 32'h0000_0000;
      end else begin
         status_prev_reg <= status_word;
      end
   end
   always_comb begin
      fb.set_bits = status_word & ~status_prev_reg;
      fb.set_bits[adcif_pkg::NEW_RESULT_BIT] = conv_done;
      fb.clear_bits = wr_clear ? wdata : 32'h0000_0000;
   end
   assign irq = |(fb.flags & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle latency
   always_comb begin
      case (addr)
         adcif_pkg::ADDR_IRQ_FLAGS: rdata_next = fb.flags;
         adcif_pkg::ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
         adcif_pkg::ADDR_LAST_RESULT: rdata_next = last_result;
         adcif_pkg::ADDR_CHANNELS_PRESENT: rdata_next = ch_impl;
         adcif_pkg::ADDR_MODULE_REVISION: rdata_next = module_revision;
         adcif_pkg::ADDR_CHANNEL_STATE: rdata_next = channel_state_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign rdata = rdata_reg;
endmodule

// [hw/adcif_pkg.sv]
// Package: register map, field layout and reset values of the converter interface registers
package adcif_pkg;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_FLAG_CLEAR = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_UNMASK = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK_OFF = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] ADDR_LAST_RESULT = 8'h2C;
   localparam logic [7:0] ADDR_CHANNELS_PRESENT = 8'h30;
   localparam logic [7:0] ADDR_MODULE_REVISION = 8'h34;
   localparam logic [7:0] ADDR_CHANNEL_ON = 8'h40;
   localparam logic [7:0] ADDR_CHANNEL_OFF = 8'h44;
   localparam logic [7:0] ADDR_CHANNEL_STATE = 8'h48;
   // Implemented interrupt sources in the flag layout
   localparam logic [31:0] IRQ_BITS = 32'h0000_7333;
   localparam int NEW_RESULT_BIT = 0;
   localparam int TAG_LSB = 16;
   localparam int TAG_W = 8;
   localparam int RESULT_W = 12;
   localparam logic [31:0] CHANNELS_PRESENT_RST = 32'h0000_03FF;
   // Revision value is arbitrary
   localparam logic [11:0] REVISION_NUMBER = 12'h001;
   localparam logic [3:0] REVISION_VARIANT = 4'h0;
   localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] CHANNEL_STATE_RST = 32'h0000_0000;
   localparam logic [31:0] LAST_RESULT_RST = 32'h0000_0000;
endpackage

// [hw/adcif_flag_if.sv]
// Interface: flag bank connection between the register block and its sticky flags
`timescale 1ns/1ps
interface adcif_flag_if;
   logic [31:0] set_bits;
   logic [31:0] clear_bits;
   logic [31:0] flags;
   modport owner (input set_bits, input clear_bits, output flags);
   modport user (output set_bits, output clear_bits, input flags);
endinterface

// [hw/adcif_flags.sv]
// Sticky interrupt flag bank, set wins over clear
`timescale 1ns/1ps
module adcif_flags #(
   parameter logic [31:0] IMPL = 32'hFFFF_FFFF
) (
   input wire logic ref_clk,
   input wire logic rstn,
   adcif_flag_if.owner fb
);
   logic [31:0] flags_reg;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flags_reg <= adcif_pkg::IRQ_FLAGS_RST;
      end else begin
         flags_reg <= ((flags_reg & ~fb.clear_bits) | fb.set_bits) & IMPL;
      end
   end
   assign fb.flags = flags_reg;
endmodule

// [tb/adcif_regs_props.sv]
// Port checks for the converter interface register tail
`timescale 1ns/1ps
module adcif_regs_props #(
   parameter int NUM_CH = 10
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata,
   input wire logic conv_done,
   input wire logic [11:0] conv_value,
   input wire logic [7:0] conv_channel,
   input wire logic [31:0] status_word,
   input wire logic [NUM_CH-1:0] channel_enable,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_ch_on_sets: assert property (wr_en && addr == 8'h40
      |=> channel_enable == ($past(channel_enable) | $past(wdata[NUM_CH-1:0]))) else $error("channel on");
   a_ch_off_clears: assert property (wr_en && addr == 8'h44
      |=> channel_enable == ($past(channel_enable) & ~$past(wdata[NUM_CH-1:0]))) else $error("channel off");
   a_state_read: assert property (rd_en && addr == 8'h48
      |=> rdata == 32'($past(channel_enable))) else $error("channel state");
   a_present_read: assert property (rd_en && addr == 8'h30
      |=> rdata == 32'h000003FF) else $error("present");
   a_result_read: assert property (conv_done ##1 !conv_done ##1 (rd_en && addr == 8'h2C)
      |=> rdata == {8'h00, $past(conv_channel, 3), 4'h0, $past(conv_value, 3)}) else $error("result");
   a_mask_field: assert property (rd_en && addr == 8'h28
      |=> (rdata & ~32'h00007333) == '0) else $error("mask field");
   a_mask_off_irq: assert property (wr_en && addr == 8'h24 && wdata == 32'hFFFFFFFF
      |=> !irq) else $error("irq masked");
   a_rdata_idle: assert property (!rd_en |=> rdata == '0) else $error("rdata idle");
endmodule
bind adcif_regs adcif_regs_props #(.NUM_CH(NUM_CH)) i_props (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_done(conv_done), .conv_value(conv_value),
   .conv_channel(conv_channel), .status_word(status_word), .channel_enable(channel_enable), .irq(irq));

// [tb/adcif_regs_bench.sv]
// Bench for the converter interface register tail
`timescale 1ns/1ps
module adcif_regs_bench;
   logic ref_clk = '0, rstn = '0, wr_en = '0, rd_en = '0, conv_done = '0, irq;
   logic [7:0] addr = '0, conv_channel = '0;
   logic [11:0] conv_value = '0;
   logic [9:0] channel_enable;
   logic [31:0] wdata = '0, rdata, status_word = '0, ch = '0, msk = '0, flg = '0, prev = '0, d;
   int miscompares = 0, checks_done = 0;
   adcif_regs i_adcif_regs (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .conv_done(conv_done), .conv_value(conv_value), .conv_channel(conv_channel),
      .status_word(status_word), .channel_enable(channel_enable), .irq(irq));
   initial forever #12.5 ref_clk = ~ref_clk;
   //////////
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk("rdata", rdata, exp);
      chk("irq", 32'(irq), 32'(|(flg & msk)));
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   //////////
   initial begin
      repeat (2000) @(posedge ref_clk);
      miscompares++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hFB9DAA0D));
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(8'h28, '0);
      rd(8'h2C, '0);
      rd(8'h30, 32'h000003FF);
      rd(8'h34, {12'h000, adcif_pkg::REVISION_VARIANT, 4'h0, adcif_pkg::REVISION_NUMBER});
      rd(8'h3C, '0);
      for (int i = 0; i < 12; i++) begin
         d = $urandom;
         // No conversion runs while channels are switched
         wr(i[0] ? 8'h44 : 8'h40, d);
         ch = i[0] ? ch & ~d : (ch | d) & 32'h3FF;
         rd(8'h48, ch);
         chk("channel_enable", 32'(channel_enable), ch);
      end
      wr(8'h20, '1);
      msk = 32'h7333;
      rd(8'h28, msk);
      d = $urandom;
      wr(8'h24, d);
      msk = msk & ~d;
      rd(8'h28, msk);
      wr(8'h20, '1);
      msk = 32'h7333;
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         @(posedge ref_clk);
         conv_done <= 1'b1;
         conv_value <= d[11:0];
         conv_channel <= d[23:16];
         status_word <= d;
         @(posedge ref_clk);
         conv_done <= 1'b0;
         flg = flg | 32'h1 | (d & ~prev & 32'h7332);
         prev = d;
         rd(8'h2C, d & 32'h00FF0FFF);
         rd(8'h18, flg);
         d = $urandom;
         wr(8'h1C, d);
         flg = flg & ~d;
      end
      rd(8'h18, flg);
      // Clear of all flags in the cycle of a conversion end: set wins
      @(posedge ref_clk);
      conv_done <= 1'b1;
      addr <= 8'h1C;
      wdata <= '1;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      wr_en <= 1'b0;
      flg = 32'h1;
      rd(8'h18, flg);
      wr(8'h24, '1);
      msk = '0;
      rd(8'h28, '0);
      wrap_up;
   end
endmodule
